// *** bench/clk_switch_monitor.sv ***
// Checker for the clock switch and power-down block.
// Assumes it is bound to the top module and sees its ports only.
`default_nettype none
module clk_switch_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        hw_reset_req,
  input wire logic        soft_reset_req,
  input wire logic        slow_osc_en,
  input wire logic [1:0]  sys_clk_src,
  input wire logic        xin_gpio_release,
  input wire logic        cpu_freeze,
  input wire logic        port_hold,
  input wire logic        flash_stop,
  input wire logic        cpu_init,
  input wire logic        wake_isr_go
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Bus and power-down relations
  // ==========================================
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property ($rose(psel && penable) |=> pready) else $error("pready not one cycle after access");
  apb_pulse_a: assert property (pready |=> !pready) else $error("pready held two cycles");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero outside answer");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  src_legal_a: assert property (sys_clk_src != 2'b11) else $error("reserved source in use");
  pin_release_a: assert property ((sys_clk_src == 2'b01 && $past(sys_clk_src) == 2'b01) |-> !xin_gpio_release)
    else $error("pin released while external in use");
  hold_ports_a: assert property (port_hold == cpu_freeze) else $error("port hold differs from freeze");
  flash_down_a: assert property ((flash_stop && $past(flash_stop)) |-> cpu_freeze && !slow_osc_en)
    else $error("flash stopped while running");
  init_pulse_a: assert property (cpu_init |=> !cpu_init) else $error("cpu_init longer than a cycle");
  isr_thaw_a: assert property (wake_isr_go |-> ##[0:1] !cpu_freeze) else $error("freeze kept after wake");
  soft_ignored_a: assert property ((flash_stop && soft_reset_req && !hw_reset_req) |=> !cpu_init)
    else $error("soft reset woke the device");
endmodule // clk_switch_monitor

bind clock_source_switch_powerdown clk_switch_monitor u_clk_switch_monitor (
  .pclk, .presetn, .psel, .penable, .pready, .prdata, .pslverr, .hw_reset_req, .soft_reset_req,
  .slow_osc_en, .sys_clk_src, .xin_gpio_release, .cpu_freeze, .port_hold, .flash_stop, .cpu_init, .wake_isr_go);
`default_nettype wire

// *** bench/clock_source_switch_powerdown_test.sv ***
// Bench for the clock switch and power-down block, APB master tasks.
// Assumes the register map header is on the include path.
`default_nettype none
`include "clk_switch_map.vh"
module clock_source_switch_powerdown_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Addresses, four bytes per index
  // ==========================================
  localparam logic [11:0] A_PWR = {`PWR_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_SW  = {`CLK_SW_IDX, 2'b00};
  localparam logic [11:0] A_EN  = {`CLK_EN_IDX, 2'b00};
  localparam logic [11:0] A_TA  = {`TA_IDX, 2'b00};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [3:0]  pstrb = 4'h0;
  logic        hw_reset_req = 1'b0, soft_reset_req = 1'b0, rerr, got;
  logic        ext_int_wake = 1'b0, pin_int_wake = 1'b0, bor_int_wake = 1'b0;
  wire         pready, pslverr, fast_osc_en, slow_osc_en, ext_clk_input_en, xin_gpio_release;
  wire         cpu_freeze, port_hold, flash_stop, cpu_init, wake_isr_go;
  wire [31:0]  prdata;
  wire [1:0]   sys_clk_src;
  int          bad_count = 0, n_tests = 0, n;
  // Clock, 8 ns period
  always #4 pclk = ~pclk;
  clock_source_switch_powerdown u_clock_source_switch_powerdown (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .hw_reset_req, .soft_reset_req, .ext_int_wake, .pin_int_wake, .bor_int_wake, .fast_osc_en,
    .slow_osc_en, .ext_clk_input_en, .sys_clk_src, .xin_gpio_release, .cpu_freeze, .port_hold,
    .flash_stop, .cpu_init, .wake_isr_go);
  // ==========================================
  // Tasks
  // ==========================================
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle, so a following call never sets a signal twice in one step
    @(posedge pclk);
    if (k >= 20) chk("pready", 1'b0, 1'b1);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  // Unlock, then protected write
  task automatic pwr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, A_TA, 32'haa);
    apb(1'b1, A_TA, 32'h55);
    apb(1'b1, a, d);
  endtask
  // Watchdog, about four times the expected run
  initial begin
    repeat (6000) @(posedge pclk);
    bad_count++;
    final_report();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("sw_rst", A_SW, 32'h30);
    rchk("en_rst", A_EN, 32'h30);
    rchk("pwr_rst", A_PWR, 32'h0);
    chk("src_rst", sys_clk_src, 2'b00);
    chk("gpio_rst", xin_gpio_release, 1'b1);
    chk("slow_on", slow_osc_en, 1'b1);
    apb(1'b1, A_EN, 32'hf0);
    rchk("locked", A_EN, 32'h30);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped", rerr, 1'b1);
    pwr(A_EN, 32'h00);
    rchk("keep_active", A_EN, 32'h30);
    chk("fast_kept", fast_osc_en, 1'b1);
    pwr(A_SW, 32'h02);
    rchk("fault_dis", A_EN, 32'h31);
    rchk("sel_upd", A_SW, 32'h32);
    pwr(A_EN, 32'hf0);
    pwr(A_SW, 32'h02);
    rchk("fault_warm", A_EN, 32'hf1);
    chk("ext_on", ext_clk_input_en, 1'b1);
    chk("old_src", sys_clk_src, 2'b00);
    repeat (260) @(posedge pclk);
    chk("ext_src", sys_clk_src, 2'b01);
    chk("pin_used", xin_gpio_release, 1'b0);
    rchk("fault_clr", A_EN, 32'hf0);
    rchk("ext_st", A_SW, 32'h3a);
    pwr(A_SW, 32'h04);
    repeat (3) @(posedge pclk);
    chk("slow_src", sys_clk_src, 2'b10);
    pwr(A_EN, 32'hc0);
    chk("fast_off", fast_osc_en, 1'b0);
    rchk("fast_st0", A_SW, 32'h1c);
    pwr(A_SW, 32'h06);
    rchk("rsvd_fault", A_EN, 32'hd1);
    chk("rsvd_src", sys_clk_src, 2'b10);
    pwr(A_EN, 32'he0);
    chk("fast_on", fast_osc_en, 1'b1);
    // Legal switch: poll the stable bit before selecting
    n = 0;
    do begin
      apb(1'b0, A_SW, 32'h0);
      n++;
    end while (rdat[`FAST_ST_BIT] !== 1'b1 && n < 100);
    chk("fast_poll", rdat[`FAST_ST_BIT], 1'b1);
    pwr(A_SW, 32'h00);
    repeat (3) @(posedge pclk);
    chk("fast_src", sys_clk_src, 2'b00);
    rchk("fault_ok", A_EN, 32'hf0);
    // Power-down, then leave by ext, pin, brown-out wake and reset
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, A_PWR, 32'h2);
      repeat (4) @(posedge pclk);
      chk("freeze", cpu_freeze, 1'b1);
      chk("flash", flash_stop, 1'b1);
      chk("hold", port_hold, 1'b1);
      chk("osc_off", slow_osc_en, 1'b0);
      soft_reset_req <= 1'b1;
      repeat (3) @(posedge pclk);
      soft_reset_req <= 1'b0;
      chk("soft_down", cpu_freeze, 1'b1);
      {hw_reset_req, bor_int_wake, pin_int_wake, ext_int_wake} <= 4'h1 << k;
      @(posedge pclk);
      {hw_reset_req, bor_int_wake, pin_int_wake, ext_int_wake} <= 4'h0;
      n = 0;
      got = 1'b0;
      while (got !== 1'b1 && n < 400) begin
        @(posedge pclk);
        n++;
        got = (k == 3) ? (cpu_init === 1'b1) : (wake_isr_go === 1'b1);
      end
      chk("wake", got, 1'b1);
      repeat (2) @(posedge pclk);
      chk("thawed", cpu_freeze, 1'b0);
      rchk("pd_clr", A_PWR, 32'h0);
    end
    final_report();
  end
endmodule // clock_source_switch_powerdown_test
`default_nettype wire

// *** hw/clk_switch_map.vh ***
// Register indices, field positions, reset values and timing counts for the
// clock source switch and power-down block. Definitions only.
`ifndef CLK_SWITCH_MAP_VH
`define CLK_SWITCH_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define PWR_CTRL_IDX   10'h087
`define CLK_SW_IDX     10'h096
`define CLK_EN_IDX     10'h097
`define TA_IDX         10'h0c7

// ==========================================================================
// Field positions
// ==========================================================================
`define PD_BIT         1
`define SEL_LO         1
`define SEL_HI         2
`define EXT_ST_BIT     3
`define SLOW_ST_BIT    4
`define FAST_ST_BIT    5
`define FAULT_BIT      0
`define FAST_EN_BIT    5
`define SLOW_EN_BIT    4
`define EXT_EN_LO      6
`define EXT_EN_HI      7

// ==========================================================================
// Codes and reset values
// ==========================================================================
`define SRC_FAST       2'b00
`define SRC_EXT        2'b01
`define SRC_SLOW       2'b10
`define SRC_RSVD       2'b11
`define EXT_ON         2'b11
`define CLK_EN_RST     8'h30
`define CLK_SW_RST     8'h30
`define TA_KEY1        8'haa
`define TA_KEY2        8'h55

// ==========================================================================
// Timing: oscillator warm-up, 8 ns clock period
// ==========================================================================
`define CLK_PERIOD_PS  8000
`define WARM_NS        2000
`define WARM_CYC       ((`WARM_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// *** hw/clock_source_switch_powerdown.v ***
// System clock source selection and power-down control, APB register slave.
// Assumes all inputs synchronous to pclk; wake and reset requests are
// already gated by their enables outside this block.
//
// Operation
// - Power-down bit stops clock, freezes CPU
// - Power-down keeps RAM and port outputs
// - Flash stopped during power-down
// - All resets but software reset wake
// - Pin or power-on reset restarts CPU; hw_reset_req is ignored while in PM_WAKE
// - External interrupt restarts clock, then service
// - Only external, pin, brown-out interrupts wake
// - Fast, slow, external sources selectable
// - Fast oscillator enabled by enable bit 5
// - Slow oscillator runs from power-up
// - Reset: both oscillators on, fast selected
// - Internal source releases external pin
// - Protected writes need unlock sequence
// - Disabling active source is ignored
// - Select disabled source: update field, fault
// - Unstable target: fault, background switch
// - Status bits mean enabled and stable
// - Select codes 00 fast, 01 ext, 10 slow
// - Select field reads unreliably; here it reads back as last written
// - Hardware clears power-down bit on wake
// - External input on only when field 11
// - Fault flag bit 0, read-only
//
// Added by the designer: register access over APB.
`default_nettype none
`include "clk_switch_map.vh"

module clock_source_switch_powerdown (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        hw_reset_req,
  input  wire        soft_reset_req,
  input  wire        ext_int_wake,
  input  wire        pin_int_wake,
  input  wire        bor_int_wake,
  output reg         fast_osc_en,
  output reg         slow_osc_en,
  output reg         ext_clk_input_en,
  output reg  [1:0]  sys_clk_src,
  output reg         xin_gpio_release,
  output reg         cpu_freeze,
  output reg         port_hold,
  output reg         flash_stop,
  output reg         cpu_init,
  output reg         wake_isr_go
);

  // =========================================================================
  // Local codes
  // =========================================================================
  localparam [1:0] PM_RUN  = 2'b00;  // Normal operation
  localparam [1:0] PM_DOWN = 2'b01;  // Clock stopped
  localparam [1:0] PM_WAKE = 2'b10;  // Waiting for clock to settle
  localparam [1:0] TA_IDLE = 2'b00;  // No key seen
  localparam [1:0] TA_HALF = 2'b01;  // First key seen
  localparam [1:0] TA_OPEN = 2'b10;  // Next protected write allowed

  localparam [7:0] EN_RST = `CLK_EN_RST;
  localparam [7:0] SW_RST = `CLK_SW_RST;

  // =========================================================================
  // State
  // =========================================================================
  reg [1:0] pm_st_ff;    // Power mode
  reg [1:0] ta_st_ff;    // Unlock sequencer
  reg       pd_bit_ff;   // Power-down request bit
  reg       fast_en_ff;  // Fast oscillator enable
  reg [1:0] ext_fld_ff;  // External input enable field
  reg       fault_ff;    // Switch fault flag
  reg [1:0] sel_ff;      // Last written select field
  reg [1:0] act_ff;      // Source actually in use
  reg       pend_ff;     // Background switch waiting

  reg [1:0] nxt_pm;
  reg [1:0] nxt_ta;
  reg       nxt_pd;
  reg       nxt_fast_en;
  reg [1:0] nxt_ext_fld;
  reg       nxt_fault;
  reg [1:0] nxt_sel;
  reg [1:0] nxt_act;
  reg       nxt_pend;
  reg       nxt_init;
  reg       nxt_isr;
  reg [31:0] nxt_rdata;
  reg        nxt_err;

  // =========================================================================
  // Source enables and stability
  // =========================================================================
  wire       sleep = (pm_st_ff == PM_DOWN);
  wire [2:0] src_en;   // Indexed by source code
  wire [2:0] osc_run;  // Enable gated by power-down
  wire [2:0] stable;   // Warm-up complete

  assign src_en[0] = fast_en_ff;
  assign src_en[1] = (ext_fld_ff == `EXT_ON);
  assign src_en[2] = 1'b1;                    // No off switch
  // All sources stop in power-down for lowest draw
  assign osc_run   = src_en & {3{~sleep}};

  // One warm-up tracker per source; fast and slow are settled at reset
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_osc
      osc_warmup #(
        .RESET_STABLE (gi != 1)
      ) u_warm (
        .pclk      (pclk),
        .presetn   (presetn),
        .osc_on    (osc_run[gi]),
        .stable_ff (stable[gi])
      );
    end
  endgenerate

  // Four-entry views so the reserved code indexes a zero
  wire [3:0] en4  = {1'b0, src_en};
  wire [3:0] st4  = {1'b0, stable & osc_run};

  // =========================================================================
  // APB decode; access completes in the second access-phase cycle
  // =========================================================================
  wire       acc    = psel & penable & pready;
  wire       wr     = acc & pwrite & pstrb[0];
  wire [9:0] widx   = paddr[11:2];
  wire       hit_pc = (widx == `PWR_CTRL_IDX);
  wire       hit_sw = (widx == `CLK_SW_IDX);
  wire       hit_en = (widx == `CLK_EN_IDX);
  wire       hit_ta = (widx == `TA_IDX);
  wire       mapped = hit_pc | hit_sw | hit_en | hit_ta;
  wire       unlock = (ta_st_ff == TA_OPEN);
  wire [7:0] wbyte  = pwdata[7:0];

  // Proposed enable set from a clock-enable write
  wire [1:0] w_ext  = wbyte[`EXT_EN_HI:`EXT_EN_LO];
  wire [3:0] w_en4  = {1'b0, 1'b1, (w_ext == `EXT_ON), wbyte[`FAST_EN_BIT]};
  wire [1:0] w_sel  = wbyte[`SEL_HI:`SEL_LO];

  // =========================================================================
  // Next-state logic
  // =========================================================================
  always @* begin
    nxt_pm      = pm_st_ff;
    nxt_ta      = ta_st_ff;
    nxt_pd      = pd_bit_ff;
    nxt_fast_en = fast_en_ff;
    nxt_ext_fld = ext_fld_ff;
    nxt_fault   = fault_ff;
    nxt_sel     = sel_ff;
    nxt_act     = act_ff;
    nxt_pend    = pend_ff;
    nxt_init    = 1'b0;
    nxt_isr     = 1'b0;

    // Unlock sequencer: two keys, then one protected write
    if (wr && hit_ta) begin
      if (wbyte == `TA_KEY1) begin
        nxt_ta = TA_HALF;
      end else if (wbyte == `TA_KEY2 && ta_st_ff == TA_HALF) begin
        nxt_ta = TA_OPEN;
      end else begin
        nxt_ta = TA_IDLE;
      end
    end else if (wr) begin
      nxt_ta = TA_IDLE;  // Any other write spends the window
    end

    // Background switch once a pending target settles
    if (pend_ff && st4[sel_ff] && !sleep) begin
      nxt_act   = sel_ff;
      nxt_fault = 1'b0;
      nxt_pend  = 1'b0;
    end

    // Clock enable write, protected
    if (wr && hit_en && unlock) begin
      // Turning off the source in use drops the whole write
      if (w_en4[act_ff]) begin
        nxt_fast_en = wbyte[`FAST_EN_BIT];
        nxt_ext_fld = w_ext;
      end
    end

    // Select write, protected
    if (wr && hit_sw && unlock) begin
      nxt_sel = w_sel;  // Field always updates
      if (!en4[w_sel]) begin
        nxt_fault = 1'b1;  // Disabled or reserved, clock kept
        nxt_pend  = 1'b0;
      end else if (!st4[w_sel]) begin
        nxt_fault = 1'b1;  // Wait in the background
        nxt_pend  = 1'b1;
      end else begin
        nxt_act   = w_sel;
        nxt_fault = 1'b0;
        nxt_pend  = 1'b0;
      end
    end

    // Power control write is not protected
    if (wr && hit_pc && wbyte[`PD_BIT]) begin
      nxt_pd = 1'b1;
    end

    // Power mode sequencing
    case (pm_st_ff)
      PM_RUN: begin
        if (hw_reset_req || soft_reset_req) begin
          nxt_init = 1'b1;
        end
        if (pd_bit_ff) begin
          nxt_pm = PM_DOWN;
        end
      end
      PM_DOWN: begin
        if (hw_reset_req) begin
          nxt_pm   = PM_RUN;  // Software reset does not count
          nxt_pd   = 1'b0;
          nxt_init = 1'b1;
        end else if (ext_int_wake || pin_int_wake || bor_int_wake) begin
          nxt_pm = PM_WAKE;
          nxt_pd = 1'b0;      // Cleared before service
        end
      end
      PM_WAKE: begin
        // Service starts only on a settled clock
        if (st4[act_ff]) begin
          nxt_pm  = PM_RUN;
          nxt_isr = 1'b1;
        end
      end
      default: begin
        nxt_pm = PM_RUN;
      end
    endcase
  end

  // =========================================================================
  // Read data; select field reads as written
  // =========================================================================
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    if (hit_sw) begin
      nxt_rdata[`FAST_ST_BIT]     = st4[0];
      nxt_rdata[`SLOW_ST_BIT]     = st4[2];
      nxt_rdata[`EXT_ST_BIT]      = st4[1];
      nxt_rdata[`SEL_HI:`SEL_LO]  = sel_ff;
    end else if (hit_en) begin
      nxt_rdata[`EXT_EN_HI:`EXT_EN_LO] = ext_fld_ff;
      nxt_rdata[`FAST_EN_BIT]          = fast_en_ff;
      // Slow source has no off switch, so its bit keeps the reset value
      nxt_rdata[`SLOW_EN_BIT]          = EN_RST[`SLOW_EN_BIT];
      nxt_rdata[`FAULT_BIT]            = fault_ff;
    end else if (hit_pc) begin
      nxt_rdata[`PD_BIT] = pd_bit_ff;
    end else if (!mapped) begin
      nxt_err = 1'b1;  // Unmapped index
    end
  end

  // =========================================================================
  // Registers
  // =========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_st_ff   <= PM_RUN;
      ta_st_ff   <= TA_IDLE;
      pd_bit_ff  <= 1'b0;
      fast_en_ff <= EN_RST[`FAST_EN_BIT];
      ext_fld_ff <= EN_RST[`EXT_EN_HI:`EXT_EN_LO];
      fault_ff   <= EN_RST[`FAULT_BIT];
      sel_ff     <= SW_RST[`SEL_HI:`SEL_LO];
      act_ff     <= `SRC_FAST;
      pend_ff    <= 1'b0;
    end else begin
      pm_st_ff   <= nxt_pm;
      ta_st_ff   <= nxt_ta;
      pd_bit_ff  <= nxt_pd;
      fast_en_ff <= nxt_fast_en;
      ext_fld_ff <= nxt_ext_fld;
      fault_ff   <= nxt_fault;
      sel_ff     <= nxt_sel;
      act_ff     <= nxt_act;
      pend_ff    <= nxt_pend;
    end
  end

  // =========================================================================
  // APB answer: one wait state, all answer signals registered
  // =========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? nxt_rdata : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & nxt_err;
    end
  end

  // =========================================================================
  // Outputs, registered from next state so they track mode changes
  // =========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_en      <= 1'b1;
      slow_osc_en      <= 1'b1;
      ext_clk_input_en <= 1'b0;
      sys_clk_src      <= `SRC_FAST;
      xin_gpio_release <= 1'b1;
      cpu_freeze       <= 1'b0;
      port_hold        <= 1'b0;
      flash_stop       <= 1'b0;
      cpu_init         <= 1'b0;
      wake_isr_go      <= 1'b0;
    end else begin
      fast_osc_en      <= nxt_fast_en & (nxt_pm != PM_DOWN);
      slow_osc_en      <= (nxt_pm != PM_DOWN);
      ext_clk_input_en <= (nxt_ext_fld == `EXT_ON) & (nxt_pm != PM_DOWN);
      sys_clk_src      <= nxt_act;
      xin_gpio_release <= (nxt_act != `SRC_EXT);
      // CPU and peripherals frozen until service may start
      cpu_freeze       <= (nxt_pm != PM_RUN);
      // Ports keep driving, memories keep content
      port_hold        <= (nxt_pm != PM_RUN);
      flash_stop       <= (nxt_pm == PM_DOWN);
      cpu_init         <= nxt_init;
      wake_isr_go      <= nxt_isr;
    end
  end

endmodule // clock_source_switch_powerdown
`default_nettype wire

// *** hw/osc_warmup.v ***
// Warm-up tracker for one clock source: counts clock cycles after enable.
// Assumes the enable input is synchronous to pclk.
`default_nettype none
`include "clk_switch_map.vh"

module osc_warmup #(
  parameter RESET_STABLE = 1
) (
  input  wire pclk,
  input  wire presetn,
  input  wire osc_on,
  output reg  stable_ff
);

  localparam integer WARM_I = `WARM_CYC;   // Full-width count from the header
  localparam [8:0]   WARM   = WARM_I[8:0]; // Counter width, cut on purpose

  reg [8:0] cnt_ff;  // Cycles since enable

  // =========================================================================
  // Count up while enabled; any drop of the enable restarts warm-up
  // =========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff    <= 9'h000;
      stable_ff <= (RESET_STABLE != 0);
    end else if (!osc_on) begin
      cnt_ff    <= 9'h000;  // Stopped source loses stability
      stable_ff <= 1'b0;
    end else if (!stable_ff) begin
      if (cnt_ff == WARM - 9'h001) begin
        stable_ff <= 1'b1;
      end
      cnt_ff <= cnt_ff + 9'h001;
    end
  end

endmodule // osc_warmup
`default_nettype wire
